//--- qeit_consts.vh
// Operation
// RULE1: four independent 8-bit timers 0 to 3; neighbouring pairs may cascade.
// RULE2: modes: 8-bit interval, 16-bit interval, pulse generation, constant-period pwm.
// RULE3: each timer has up-counter, comparator, compare register; one toggle ff per pair.
// RULE4: prescaler derives divide-by 8, 32, 128 and 2048 ticks from system clock.
// RULE5: prescaler run bit 1 counts; 0 clears and halts the prescaler.
// RULE6: timers 0 and 2 pick div8, div32 or div128; timer 0 also external clock.
// RULE7: cascaded upper counts lower overflow, else div8, div128, div2048 or partner match.
// RULE8: pair mode 01 cascades; mode 00 with upper select 01 counts div8.
// RULE9: reset puts both pair mode fields at 00, 8-bit interval mode.
// RULE10: run register starts or stops and clears each counter; reset stops all.
// RULE11: match when counter equals compare; compare 00 matches on overflow.
// RULE12: timers 0 and 2 compare registers double buffered; enable bit resets to 0.
// RULE13: buffered value loads at pwm period overflow or pulse-generation period end.
// RULE14: one address; write sets both when buffering off, only buffer when on.
// RULE15: compare registers write-only, read as nothing, indeterminate after reset.
// RULE16: software writes compare, then enables buffering, then writes next value.
// RULE17: match clears counter, raises timer interrupt, inverts toggle ff if enabled.
// RULE18: toggle control field 00 inverts, 10 clears, 01 sets output flip-flop.
// RULE19: cascaded: lower compare write disables comparator until upper compare written.
// RULE20: cascaded: only simultaneous match clears both, raises upper interrupt, toggles.
// RULE21: running counter increments once per rising edge of its selected clock.
`ifndef QEIT_CONSTS_VH
`define QEIT_CONSTS_VH

// register offsets
`define QEIT_OFF_RUN       8'h20
`define QEIT_OFF_CMP0      8'h22
`define QEIT_OFF_CMP1      8'h23
`define QEIT_OFF_MODE_A    8'h24
`define QEIT_OFF_MODE_B    8'h25
`define QEIT_OFF_CMP2      8'h26
`define QEIT_OFF_CMP3      8'h27
`define QEIT_OFF_TFFC      8'h28
`define QEIT_OFF_DBUF      8'h29
`define QEIT_OFF_STATUS    8'h2a
`define QEIT_OFF_CNT0      8'h2c
`define QEIT_OFF_CNT1      8'h2d
`define QEIT_OFF_CNT2      8'h2e
`define QEIT_OFF_CNT3      8'h2f

// reset values
`define QEIT_RST_RUN       8'h00
`define QEIT_RST_MODE      8'h00
`define QEIT_RST_TFFC      8'h00
`define QEIT_RST_DBUF      2'h0

// field positions
`define QEIT_RUN_PRE_BIT   7
`define QEIT_MODE_PM_HI    7
`define QEIT_MODE_PM_LO    6
`define QEIT_MODE_PW_HI    5
`define QEIT_MODE_PW_LO    4
`define QEIT_MODE_US_HI    3
`define QEIT_MODE_US_LO    2
`define QEIT_MODE_LS_HI    1
`define QEIT_MODE_LS_LO    0
`define QEIT_TFFC_B_BASE   4
`define QEIT_TFFC_EN_OFS   2
`define QEIT_TFFC_SRC_OFS  3

// pair mode codes
`define QEIT_PM_8BIT       2'h0
`define QEIT_PM_16BIT      2'h1
`define QEIT_PM_PPG        2'h2
`define QEIT_PM_PWM        2'h3

// toggle control codes
`define QEIT_TFF_INVERT    2'h0
`define QEIT_TFF_SET       2'h1
`define QEIT_TFF_CLEAR     2'h2
`define QEIT_TFF_KEEP      2'h3

// prescaler: 2-bit predivider followed by 9-bit prescaler, tick terminal counts
`define QEIT_PRE_W         11
`define QEIT_DIV8_TERM     3'h7
`define QEIT_DIV32_TERM    5'h1f
`define QEIT_DIV128_TERM   7'h7f
`define QEIT_DIV2048_TERM  11'h7ff

// pwm period masks (2^6, 2^7, 2^8)
`define QEIT_PWM_MASK6     8'h3f
`define QEIT_PWM_MASK7     8'h7f
`define QEIT_PWM_MASK8     8'hff

`endif

//--- qeit_prescale.v
`timescale 1ns/1ps
`default_nettype none
`include "qeit_consts.vh"

module qeit_prescale (
	// clock and reset
	input  wire clk,
	input  wire rst_n,
	// control
	input  wire run,
	// divided ticks, one cycle each
	output wire tick_div8,
	output wire tick_div32,
	output wire tick_div128,
	output wire tick_div2048
);

	reg [`QEIT_PRE_W-1:0] cnt_q;

	// stopping clears the count so every restart begins a full period
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= {`QEIT_PRE_W{1'b0}};
		end else if (!run) begin
			cnt_q <= {`QEIT_PRE_W{1'b0}}; // RULE5
		end else begin
			cnt_q <= cnt_q + {{(`QEIT_PRE_W-1){1'b0}}, 1'b1}; // RULE5
		end
	end

	// a tick marks the cycle before the tap bit falls
	assign tick_div8    = run && (cnt_q[2:0] == `QEIT_DIV8_TERM); // RULE4
	assign tick_div32   = run && (cnt_q[4:0] == `QEIT_DIV32_TERM); // RULE4
	assign tick_div128  = run && (cnt_q[6:0] == `QEIT_DIV128_TERM); // RULE4
	assign tick_div2048 = run && (cnt_q == `QEIT_DIV2048_TERM); // RULE4

endmodule // qeit_prescale
`default_nettype wire

//--- qeit_upcount.v
`timescale 1ns/1ps
`default_nettype none

module qeit_upcount #(
	parameter W = 8
) (
	// clock and reset
	input  wire         clk,
	input  wire         rst_n,
	// control
	input  wire         clr,
	input  wire         inc,
	// state
	output reg  [W-1:0] cnt_q,
	output wire [W-1:0] cnt_next,
	output wire         ovf
);

	// value the counter takes if not cleared; comparators look ahead at it
	assign cnt_next = inc ? (cnt_q + {{(W-1){1'b0}}, 1'b1}) : cnt_q;
	assign ovf      = inc && (&cnt_q);

	// clear beats increment, so a match restarts the period at zero
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= {W{1'b0}}; // RULE10
		end else if (clr) begin
			cnt_q <= {W{1'b0}}; // RULE10
		end else if (inc) begin
			cnt_q <= cnt_next; // RULE21
		end
	end

endmodule // qeit_upcount
`default_nettype wire

//--- qeit_top.v
`timescale 1ns/1ps
`default_nettype none
`include "qeit_consts.vh"

module qeit_top (
	// clock and reset
	input  wire       CORE_CLK,
	input  wire       NRST,
	// register port
	input  wire [7:0] REG_ADDR,
	input  wire [7:0] REG_WDATA,
	input  wire       REG_WR,
	input  wire       REG_RD,
	output reg  [7:0] REG_RDATA,
	// external count clock for timer 0
	input  wire       EXT_COUNT_CLOCK_IN,
	// pair outputs
	output wire       TOGGLE_OUT_PAIR_A,
	output wire       TOGGLE_OUT_PAIR_B,
	// per-timer interrupt pulses, upper_timer_irq is bit 1 for pair a and bit 3 for pair b
	output wire [3:0] TIMER_IRQ
);

	// pick one of four tick sources by a 2-bit select
	function sel4;
		input [1:0] sel;
		input       s0;
		input       s1;
		input       s2;
		input       s3;
		begin
			case (sel)
				2'h0:    sel4 = s0;
				2'h1:    sel4 = s1;
				2'h2:    sel4 = s2;
				default: sel4 = s3;
			endcase
		end
	endfunction

	// pwm period mask from the width select; 00 and 01 both give 2^6
	function [7:0] pwm_mask;
		input [1:0] sel;
		begin
			case (sel)
				2'h2:    pwm_mask = `QEIT_PWM_MASK7;
				2'h3:    pwm_mask = `QEIT_PWM_MASK8;
				default: pwm_mask = `QEIT_PWM_MASK6;
			endcase
		end
	endfunction

	// control registers
	reg  [7:0] run_control_reg_q;
	reg  [7:0] pair_a_mode_reg_q;
	reg  [7:0] pair_b_mode_reg_q;
	reg  [7:0] toggle_ff_control_reg_q;
	reg  [1:0] double_buffer_control_reg_q;
	reg        ext_q;

	// shared state gathered from both pairs
	wire [1:0]  toggle_out;
	wire [1:0]  cmp_hold;
	wire [31:0] cnt_all;
	wire        ext_rise;
	wire        prescale_div8;
	wire        prescale_div32;
	wire        prescale_div128;
	wire        prescale_div2048;
	wire        wr_tffc;

	assign wr_tffc = REG_WR && (REG_ADDR == `QEIT_OFF_TFFC);

	// control register writes
	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			run_control_reg_q           <= `QEIT_RST_RUN; // RULE10
			pair_a_mode_reg_q           <= `QEIT_RST_MODE; // RULE9
			pair_b_mode_reg_q           <= `QEIT_RST_MODE; // RULE9
			toggle_ff_control_reg_q     <= `QEIT_RST_TFFC;
			double_buffer_control_reg_q <= `QEIT_RST_DBUF; // RULE12
		end else if (REG_WR) begin
			case (REG_ADDR)
				`QEIT_OFF_RUN:    run_control_reg_q <= REG_WDATA;
				`QEIT_OFF_MODE_A: pair_a_mode_reg_q <= REG_WDATA;
				`QEIT_OFF_MODE_B: pair_b_mode_reg_q <= REG_WDATA;
				`QEIT_OFF_TFFC:   toggle_ff_control_reg_q <= REG_WDATA;
				`QEIT_OFF_DBUF:   double_buffer_control_reg_q <= REG_WDATA[1:0]; // RULE12
				default:          run_control_reg_q <= run_control_reg_q;
			endcase
		end
	end

	// the pin is already synchronous, so one flop is enough for edge detection
	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			ext_q <= 1'b0;
		end else begin
			ext_q <= EXT_COUNT_CLOCK_IN;
		end
	end

	assign ext_rise = EXT_COUNT_CLOCK_IN && !ext_q; // RULE21

	qeit_prescale u_prescale (
		.clk          (CORE_CLK),
		.rst_n        (NRST),
		.run          (run_control_reg_q[`QEIT_RUN_PRE_BIT]),
		.tick_div8    (prescale_div8),
		.tick_div32   (prescale_div32),
		.tick_div128  (prescale_div128),
		.tick_div2048 (prescale_div2048)
	);

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : pair // RULE1
			wire [7:0] mode;
			wire [1:0] pm;
			wire [3:0] tctl;
			wire       dbe;
			wire       run_lo;
			wire       run_hi;
			wire       tick_lo;
			wire       tick_hi;
			wire       inc_lo;
			wire       inc_hi;
			wire [7:0] cnt_lo;
			wire [7:0] cnt_hi;
			wire [7:0] nxt_lo;
			wire [7:0] nxt_hi;
			wire       ovf_lo;
			wire       eq_lo;
			wire       eq_hi;
			wire       lo_match;
			wire       hi_match;
			wire       both_match;
			wire       ppg_end;
			wire       pwm_end;
			wire       wr_lo;
			wire       wr_hi;
			reg        clr_lo;
			reg        clr_hi;
			reg        tog_evt;
			reg        irq_lo;
			reg        irq_hi;
			reg        xfer;
			reg  [7:0] cmp_lo_q;
			reg  [7:0] buf_lo_q;
			reg  [7:0] cmp_hi_q;
			reg        hold_q;
			reg        tff_q;
			reg        irq_lo_q;
			reg        irq_hi_q;

			assign mode   = (g == 0) ? pair_a_mode_reg_q : pair_b_mode_reg_q;
			assign pm     = mode[`QEIT_MODE_PM_HI:`QEIT_MODE_PM_LO];
			assign tctl   = toggle_ff_control_reg_q[g*4+3:g*4];
			assign dbe    = double_buffer_control_reg_q[g];
			assign run_lo = run_control_reg_q[2*g];
			assign run_hi = run_control_reg_q[2*g+1];
			assign wr_lo  = REG_WR && (REG_ADDR == ((g == 0) ? `QEIT_OFF_CMP0 : `QEIT_OFF_CMP2));
			assign wr_hi  = REG_WR && (REG_ADDR == ((g == 0) ? `QEIT_OFF_CMP1 : `QEIT_OFF_CMP3));

			// lower clock; select 00 is the pin on pair a and no clock on pair b
			assign tick_lo = sel4(mode[`QEIT_MODE_LS_HI:`QEIT_MODE_LS_LO],
				(g == 0) ? ext_rise : 1'b0,
				prescale_div8, prescale_div32, prescale_div128); // RULE6
			assign inc_lo = run_lo && tick_lo; // RULE21

			qeit_upcount #(.W(8)) u_lo (
				.clk      (CORE_CLK),
				.rst_n    (NRST),
				.clr      (clr_lo),
				.inc      (inc_lo),
				.cnt_q    (cnt_lo),
				.cnt_next (nxt_lo),
				.ovf      (ovf_lo)
			);

			// comparators look at the next value so the period equals the compare value;
			// compare 00 matches exactly when the counter wraps
			assign eq_lo    = (nxt_lo == cmp_lo_q); // RULE11
			assign eq_hi    = (nxt_hi == cmp_hi_q); // RULE11
			assign lo_match = inc_lo && eq_lo && !hold_q; // RULE19
			assign ppg_end  = inc_lo && (nxt_lo == cmp_hi_q);
			assign pwm_end  = inc_lo && ((cnt_lo & pwm_mask(mode[`QEIT_MODE_PW_HI:`QEIT_MODE_PW_LO]))
				== pwm_mask(mode[`QEIT_MODE_PW_HI:`QEIT_MODE_PW_LO]));

			// upper clock: lower overflow when cascaded, else a selectable source
			assign tick_hi = (pm == `QEIT_PM_16BIT) ? ovf_lo : // RULE7
				sel4(mode[`QEIT_MODE_US_HI:`QEIT_MODE_US_LO], lo_match,
				prescale_div8, prescale_div128, prescale_div2048); // RULE8
			assign inc_hi = run_hi && tick_hi && ((pm == `QEIT_PM_8BIT) || (pm == `QEIT_PM_16BIT));

			qeit_upcount #(.W(8)) u_hi (
				.clk      (CORE_CLK),
				.rst_n    (NRST),
				.clr      (clr_hi),
				.inc      (inc_hi),
				.cnt_q    (cnt_hi),
				.cnt_next (nxt_hi),
				.ovf      ()
			);

			assign hi_match   = inc_hi && eq_hi; // RULE11
			assign both_match = inc_lo && eq_lo && eq_hi && !hold_q; // RULE20

			// per-mode clearing, toggling, interrupts and buffer transfer
			always @* begin
				clr_lo  = !run_lo; // RULE10
				clr_hi  = !run_hi; // RULE10
				tog_evt = 1'b0;
				irq_lo  = 1'b0;
				irq_hi  = 1'b0;
				xfer    = 1'b0;
				case (pm) // RULE2
					`QEIT_PM_8BIT: begin
						clr_lo  = !run_lo || lo_match; // RULE17
						clr_hi  = !run_hi || hi_match; // RULE17
						irq_lo  = lo_match; // RULE17
						irq_hi  = hi_match; // RULE17
						tog_evt = tctl[`QEIT_TFFC_SRC_OFS] ? hi_match : lo_match; // RULE17
					end
					`QEIT_PM_16BIT: begin
						clr_lo  = !run_lo || both_match; // RULE20
						clr_hi  = !run_hi || both_match; // RULE20
						irq_hi  = both_match; // RULE20
						tog_evt = both_match; // RULE20
					end
					`QEIT_PM_PPG: begin
						clr_lo  = !run_lo || ppg_end;
						clr_hi  = 1'b1;
						irq_lo  = lo_match;
						tog_evt = lo_match ^ ppg_end; // coincident edges cancel
						xfer    = ppg_end; // RULE13
					end
					`QEIT_PM_PWM: begin
						clr_lo  = !run_lo || pwm_end;
						clr_hi  = 1'b1;
						irq_lo  = lo_match;
						tog_evt = lo_match ^ pwm_end;
						xfer    = pwm_end; // RULE13
					end
					default: begin
						clr_lo = 1'b1;
						clr_hi = 1'b1;
					end
				endcase
			end

			// compare data carry no reset: their value is undefined until written
			always @(posedge CORE_CLK) begin
				if (wr_lo) begin
					buf_lo_q <= REG_WDATA; // RULE14
				end
				if (wr_lo && !dbe) begin
					cmp_lo_q <= REG_WDATA; // RULE14
				end else if (dbe && xfer) begin
					cmp_lo_q <= buf_lo_q; // RULE13
				end
				if (wr_hi) begin
					cmp_hi_q <= REG_WDATA; // RULE15
				end
			end

			// lower write parks the cascaded comparator until the upper half lands
			always @(posedge CORE_CLK or negedge NRST) begin
				if (!NRST) begin
					hold_q <= 1'b0;
				end else if (wr_hi) begin
					hold_q <= 1'b0; // RULE19
				end else if (wr_lo && (pm == `QEIT_PM_16BIT)) begin
					hold_q <= 1'b1; // RULE19
				end
			end

			// software action wins over a same-cycle hardware toggle
			always @(posedge CORE_CLK or negedge NRST) begin
				if (!NRST) begin
					tff_q <= 1'b0;
				end else if (wr_tffc && (REG_WDATA[g*4+1:g*4] != `QEIT_TFF_KEEP)) begin
					case (REG_WDATA[g*4+1:g*4])
						`QEIT_TFF_INVERT: tff_q <= !tff_q; // RULE18
						`QEIT_TFF_SET:    tff_q <= 1'b1; // RULE18
						default:          tff_q <= 1'b0; // RULE18
					endcase
				end else if (tog_evt && tctl[`QEIT_TFFC_EN_OFS]) begin
					tff_q <= !tff_q; // RULE17
				end
			end

			// interrupt pulses leave through flops, one cycle after the match
			always @(posedge CORE_CLK or negedge NRST) begin
				if (!NRST) begin
					irq_lo_q <= 1'b0;
					irq_hi_q <= 1'b0;
				end else begin
					irq_lo_q <= irq_lo; // RULE17
					irq_hi_q <= irq_hi; // RULE20
				end
			end

			assign toggle_out[g]            = tff_q; // RULE3
			assign cmp_hold[g]              = hold_q;
			assign TIMER_IRQ[2*g]           = irq_lo_q;
			assign TIMER_IRQ[2*g+1]         = irq_hi_q;
			assign cnt_all[16*g+7:16*g]     = cnt_lo;
			assign cnt_all[16*g+15:16*g+8]  = cnt_hi;
		end
	endgenerate

	assign TOGGLE_OUT_PAIR_A = toggle_out[0];
	assign TOGGLE_OUT_PAIR_B = toggle_out[1];

	// read data stand one cycle only; compare registers and unmapped offsets give zero
	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			case (REG_ADDR)
				`QEIT_OFF_RUN:    REG_RDATA <= run_control_reg_q;
				`QEIT_OFF_MODE_A: REG_RDATA <= pair_a_mode_reg_q;
				`QEIT_OFF_MODE_B: REG_RDATA <= pair_b_mode_reg_q;
				// control fields are actions, so they read back as no-change
				`QEIT_OFF_TFFC:   REG_RDATA <= toggle_ff_control_reg_q | 8'h33;
				`QEIT_OFF_DBUF:   REG_RDATA <= {6'h00, double_buffer_control_reg_q};
				`QEIT_OFF_STATUS: REG_RDATA <= {toggle_out, cmp_hold, run_control_reg_q[3:0]};
				`QEIT_OFF_CNT0:   REG_RDATA <= cnt_all[7:0];
				`QEIT_OFF_CNT1:   REG_RDATA <= cnt_all[15:8];
				`QEIT_OFF_CNT2:   REG_RDATA <= cnt_all[23:16];
				`QEIT_OFF_CNT3:   REG_RDATA <= cnt_all[31:24];
				default:          REG_RDATA <= 8'h00; // RULE15
			endcase
		end else begin
			REG_RDATA <= 8'h00;
		end
	end

endmodule // qeit_top
`default_nettype wire

//--- qeit_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module qeit_monitor (
	// clock and reset
	input wire logic       CORE_CLK,
	input wire logic       NRST,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_RDATA,
	// pins
	input wire logic       EXT_COUNT_CLOCK_IN,
	input wire logic       TOGGLE_OUT_PAIR_A,
	input wire logic       TOGGLE_OUT_PAIR_B,
	input wire logic [3:0] TIMER_IRQ
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);

	logic run_q;
	logic tffc_wr;

	// shadow of the prescaler run bit, since the checker cannot see inside
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST)
			run_q <= 1'b0;
		else if (REG_WR && REG_ADDR == 8'h20)
			run_q <= REG_WDATA[7];
	end

	// write to the toggle control register
	assign tffc_wr = REG_WR && REG_ADDR == 8'h28;

	// one access of each kind
	sequence s_wr(a);
		REG_WR && REG_ADDR == a;
	endsequence
	sequence s_rd(a);
		REG_RD && REG_ADDR == a;
	endsequence

	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
		else $error("read data not zero outside read slot");
	a_cmp_read_zero: assert property (REG_RD && (REG_ADDR inside {8'h22, 8'h23, 8'h26, 8'h27})
		|=> REG_RDATA == 8'h00)
		else $error("compare register returned data");
	a_run_readback: assert property (s_wr(8'h20) ##1 s_rd(8'h20)
		|=> (REG_RDATA & 8'h8f) == ($past(REG_WDATA, 2) & 8'h8f))
		else $error("run control readback wrong");
	a_mode_readback: assert property (s_wr(8'h24) ##1 s_rd(8'h24)
		|=> REG_RDATA == $past(REG_WDATA, 2))
		else $error("pair mode readback wrong");
	a_stopped_quiet: assert property (!run_q && !$past(run_q) |-> TIMER_IRQ[3:1] == 3'h0)
		else $error("interrupt with prescaler stopped");
	a_irq_one_cycle: assert property (TIMER_IRQ != 4'h0
		|=> (TIMER_IRQ & $past(TIMER_IRQ)) == 4'h0)
		else $error("interrupt pulse longer than one cycle");
	a_tff_force_a: assert property (tffc_wr && REG_WDATA[1] != REG_WDATA[0]
		|=> TOGGLE_OUT_PAIR_A == $past(REG_WDATA[0]))
		else $error("pair a toggle set or clear failed");
	a_tff_invert_a: assert property (tffc_wr && REG_WDATA[1:0] == 2'h0
		|=> TOGGLE_OUT_PAIR_A != $past(TOGGLE_OUT_PAIR_A))
		else $error("pair a toggle invert failed");
	a_tff_force_b: assert property (tffc_wr && REG_WDATA[5] != REG_WDATA[4]
		|=> TOGGLE_OUT_PAIR_B == $past(REG_WDATA[4]))
		else $error("pair b toggle set or clear failed");
endmodule // qeit_monitor

bind qeit_top qeit_monitor i_mon (
	.CORE_CLK           (CORE_CLK),
	.NRST               (NRST),
	.REG_ADDR           (REG_ADDR),
	.REG_WDATA          (REG_WDATA),
	.REG_WR             (REG_WR),
	.REG_RD             (REG_RD),
	.REG_RDATA          (REG_RDATA),
	.EXT_COUNT_CLOCK_IN (EXT_COUNT_CLOCK_IN),
	.TOGGLE_OUT_PAIR_A  (TOGGLE_OUT_PAIR_A),
	.TOGGLE_OUT_PAIR_B  (TOGGLE_OUT_PAIR_B),
	.TIMER_IRQ          (TIMER_IRQ)
);

`default_nettype wire

//--- tb_qeit_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
	begin \
		total_checks++; \
		if ((g) !== (e)) begin \
			mismatches++; \
			$display("unexpected %s expected %0h seen %0h", nm, e, g); \
		end \
	end

module tb_qeit_top;
	localparam logic [7:0] RST_REGS [7] = '{8'h20, 8'h24, 8'h25, 8'h29, 8'h2a, 8'h2c, 8'h30};
	localparam logic [7:0] CMP_REGS [4] = '{8'h22, 8'h23, 8'h26, 8'h27};
	localparam logic [1:0] TFF_CODE [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
	localparam logic       TFF_EXP  [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
	localparam int         LO_DIV   [3] = '{8, 32, 128};
	localparam int         UP_DIV   [3] = '{8, 128, 2048};

	logic       core_clk  = 1'b0;
	logic       nrst      = 1'b0;
	logic [7:0] reg_addr  = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr    = 1'b0;
	logic       reg_rd    = 1'b0;
	logic       ext_in    = 1'b0;
	logic       ext_run   = 1'b0;
	wire  [7:0] reg_rdata;
	wire        tff_a;
	wire        tff_b;
	wire  [3:0] irq;
	int         mismatches   = 0;
	int         total_checks = 0;
	int         cyc    = 0;
	int         n_irq0 = 0;
	int         n_irq1 = 0;
	int         p;
	logic [7:0] q;
	logic       prev;

	qeit_top i_dut (
		.CORE_CLK           (core_clk),
		.NRST               (nrst),
		.REG_ADDR           (reg_addr),
		.REG_WDATA          (reg_wdata),
		.REG_WR             (reg_wr),
		.REG_RD             (reg_rd),
		.REG_RDATA          (reg_rdata),
		.EXT_COUNT_CLOCK_IN (ext_in),
		.TOGGLE_OUT_PAIR_A  (tff_a),
		.TOGGLE_OUT_PAIR_B  (tff_b),
		.TIMER_IRQ          (irq)
	);

	// 250 MHz clock
	always #2 core_clk = ~core_clk;

	// hang guard, interrupt tallies and a slow external count clock (rise every 10 cycles)
	always @(posedge core_clk) begin
		cyc++;
		n_irq0 += int'(irq[0] === 1'b1);
		n_irq1 += int'(irq[1] === 1'b1);
		if (ext_run && cyc % 5 == 0)
			ext_in <= ~ext_in;
		if (cyc == 60000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// single write, strobe dropped at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// write then read with no gap between strobes
	task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 r = reg_rdata;
	endtask

	// cycles between two interrupt pulses on one bit, 0 if none came
	task automatic period(input int b, output int pr);
		int t0;
		t0 = 0;
		pr = 0;
		for (int i = 0; i < 9000 && pr == 0; i++) begin
			@(posedge core_clk);
			#1;
			if (irq[b] === 1'b1) begin
				if (t0 != 0)
					pr = cyc - t0;
				t0 = cyc;
			end
		end
	endtask

	task automatic t_reset_and_map();
		foreach (RST_REGS[i]) begin
			rd(RST_REGS[i], q);
			`CHK("reset value", 8'h00, q)
		end
		rd(8'h28, q);
		`CHK("toggle control", 8'h33, q)
		foreach (CMP_REGS[i]) begin
			wr(CMP_REGS[i], 8'h55);
			rd(CMP_REGS[i], q);
			`CHK("compare read", 8'h00, q)
		end
		wrrd(8'h24, 8'h9b, q);
		`CHK("mode a", 8'h9b, q)
		wrrd(8'h20, 8'h80, q);
		`CHK("run control", 8'h80, q)
		wr(8'h20, 8'h00);
	endtask

	task automatic t_tff_software();
		foreach (TFF_CODE[i]) begin
			wr(8'h28, {2'h0, TFF_CODE[i], 2'h0, TFF_CODE[i]});
			#1;
			`CHK("toggle a", TFF_EXP[i], tff_a)
			`CHK("toggle b", TFF_EXP[i], tff_b)
		end
	endtask

	// every prescaler tap on both halves of pair a, compare value 2
	task automatic t_clock_select();
		for (int i = 1; i <= 3; i++) begin
			wr(8'h22, 8'h02);
			wr(8'h23, 8'h02);
			wr(8'h24, 8'(i * 5));
			wr(8'h20, 8'h83);
			period(0, p);
			`CHK("lower period", 2 * LO_DIV[i - 1], p)
			period(1, p);
			`CHK("upper period", 2 * UP_DIV[i - 1], p)
			wr(8'h20, 8'h00);
		end
	endtask

	task automatic t_interval_toggle();
		wr(8'h24, 8'h04);
		wr(8'h23, 8'h03);
		wr(8'h28, 8'h3e);
		wr(8'h20, 8'h82);
		period(1, p);
		`CHK("interval", 24, p)
		prev = tff_a;
		repeat (24) @(posedge core_clk);
		#1;
		`CHK("toggle on match", ~prev, tff_a)
		wr(8'h20, 8'h02);
		rd(8'h2d, q);
		prev = q[0];
		repeat (50) @(posedge core_clk);
		rd(8'h2d, p);
		`CHK("frozen counter", q, 8'(p))
		wr(8'h20, 8'h80);
		rd(8'h2d, q);
		`CHK("stopped counter", 8'h00, q)
		wr(8'h23, 8'h00);
		wr(8'h20, 8'h82);
		period(1, p);
		`CHK("compare zero", 2048, p)
		wr(8'h20, 8'h00);
	endtask

	task automatic t_ext_clock();
		wr(8'h24, 8'h04);
		wr(8'h22, 8'h02);
		ext_run = 1'b1;
		wr(8'h20, 8'h01);
		period(0, p);
		`CHK("external period", 20, p)
		wr(8'h20, 8'h00);
		ext_run = 1'b0;
	endtask

	task automatic t_cascade();
		wr(8'h22, 8'h02);
		wr(8'h23, 8'h01);
		wr(8'h24, 8'h41);
		wr(8'h20, 8'h83);
		n_irq0 = 0;
		period(1, p);
		`CHK("cascade period", 2064, p)
		`CHK("lower irq", 0, n_irq0)
		wr(8'h22, 8'h02);
		repeat (2) @(posedge core_clk);
		n_irq1 = 0;
		repeat (2200) @(posedge core_clk);
		`CHK("held comparator", 0, n_irq1)
		wr(8'h23, 8'h01);
		// the counters ran on while held, so restart them to measure a clean period
		wr(8'h20, 8'h80);
		wr(8'h20, 8'h83);
		period(1, p);
		`CHK("resumed period", 2064, p)
		wr(8'h20, 8'h00);
	endtask

	// pair b pwm, 64-tick period; compare 10h loaded direct, 20h through the buffer
	task automatic t_pwm_dbuf();
		wr(8'h25, 8'hc1);
		wr(8'h26, 8'h10);
		wr(8'h29, 8'h02);
		wr(8'h26, 8'h20);
		wr(8'h28, 8'h63);
		wr(8'h20, 8'h84);
		period(2, p);
		`CHK("pwm buffered load", 640, p)
		`CHK("pwm toggle on match", 1'b1, tff_b)
		repeat (255) @(posedge core_clk);
		#1;
		`CHK("pwm duty", 1'b1, tff_b)
		@(posedge core_clk);
		#1;
		`CHK("pwm period end", 1'b0, tff_b)
		wr(8'h20, 8'h00);
		wr(8'h29, 8'h00);
	endtask

	// reset, then the scenarios in turn
	initial begin
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		t_reset_and_map();
		t_tff_software();
		t_clock_select();
		t_interval_toggle();
		t_ext_clock();
		t_pwm_dbuf();
		t_cascade();
		final_report();
	end
endmodule // tb_qeit_top

`default_nettype wire
